// ### hw/tccu_top.sv
// capture/compare unit: counter, registers over APB, compare pin actions
//
// What this block does
// - capture copies whole count in one transfer
// - capture latches on stable count value
// - reset leaves capture values untouched, except the shared store, which reloads ones
// - capture bytes read-only, writes ignored
// - high-byte read delays capture one cycle
// - shared channel select picks capture or compare
// - five comparators set flags on equality, fifth only when select clear
// - flag with enable raises channel request
// - reset loads compare registers with ones
// - pin action on every match regardless of flag, except fifth while select set
// - mode/level: off, toggle, low, high
// - fifth action only when select clear
// - first channel drives masked bits seven-three
// - high-byte write inhibits compare one cycle
// - force runs action without flag
// - low three bits read zero
// - count read-only, high read latches low
// - edge field selects capture edge
// - write one clears only those flags
`timescale 1ns/1ns
`include "tccu_consts.svh"
module tccu_top
    import tccu_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        SRST_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // capture pins (bit 3 = shared channel)
    input  wire logic [3:0]  CAPTURE_PIN_I,
    // compare port bits 7..3
    output logic      [7:3]  PORT_O,
    // per-channel requests: [7:3] compare 1..5/shared, [2:0] capture 1..3
    output logic      [7:0]  IRQ_O
);
    logic [WIDTH-1:0] free_running_count;
    logic [7:0]       count_low_latch;
    logic [WIDTH-1:0] cmp_value [5];
    logic [WIDTH-1:0] cap_value [4];
    logic [3:0]       cap_event;
    logic [4:0]       cmp_match;
    logic [4:0]       cmp_inhibit;
    logic [3:0]       cap_inhibit;
    logic [7:3]       multi_pin_action_mask;
    logic [7:3]       multi_pin_action_data;
    logic [7:0]       compare_pin_action_control;
    logic [7:0]       edge_ctl;
    logic [7:0]       channel_flag_register;
    logic [7:0]       channel_interrupt_enable_register;
    logic             shared_channel_select;
    logic [4:0]       force_pending;
    logic [4:0]       act;
    logic [7:3]       next_port;
    logic             wr_en;
    logic             rd_en;
    logic             hi_sel;
    logic [11:0]      word_addr;
    logic [31:0]      next_rdata;

    // ==========================================================
    // bus decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_en     = PSEL_I && PENABLE_I && !PWRITE_I;
    assign hi_sel    = PADDR_I < `TCCU_OFF_LOWBYTE;
    assign word_addr = hi_sel ? PADDR_I : PADDR_I - `TCCU_OFF_LOWBYTE;

    // ==========================================================
    // free-running counter; captures use its registered value so it is stable
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            free_running_count <= '0;
        end else begin
            free_running_count <= free_running_count + WIDTH'(1);
        end
    end

    // high read latches low byte for the following low read
    // taken in the setup cycle, where the high byte is sampled too,
    // so a carry between setup and access cannot split the pair
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            count_low_latch <= 8'h00;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I && hi_sel && hit(word_addr, `TCCU_OFF_COUNT)) begin
            count_low_latch <= free_running_count[7:0];
        end
    end

    // ==========================================================
    // capture channels; high-byte read blocks the transfer a cycle
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cap
            tccu_cap_ctl_t ctl;
            assign ctl.enable = (g < 3) ? 1'b1 : shared_channel_select;
            assign ctl.edge_sel = tccu_edge_t'(edge_ctl[2*g+:2]);
            assign cap_inhibit[g] = rd_en && hi_sel && hit(word_addr, 12'(4*g));
            tccu_capture_chan #(.WIDTH(WIDTH)) u_cap (
                .clk_i     (CLOCK_I),
                .rst_i     (SRST_I),
                .pin_i     (CAPTURE_PIN_I[g]),
                .ctl_i     (ctl),
                .inhibit_i (cap_inhibit[g]),
                .count_i   (free_running_count),
                .value_o   (cap_value[g]),
                .event_o   (cap_event[g])
            );
        end
        for (g = 0; g < 5; g++) begin : g_cmp
            // channel 5 is the shared register at its own offset
            localparam logic [11:0] OFF = (g == 4) ? `TCCU_OFF_SHARED : 12'(`TCCU_OFF_CMP1 + 4*g);
            assign cmp_inhibit[g] = wr_en && hi_sel && hit(word_addr, OFF);
            tccu_compare_chan #(.WIDTH(WIDTH)) u_cmp (
                .clk_i     (CLOCK_I),
                .rst_i     (SRST_I),
                .value_i   (cmp_value[g]),
                .count_i   (free_running_count),
                .inhibit_i (cmp_inhibit[g]),
                .match_o   (cmp_match[g])
            );
            // compare storage, byte writable
            always_ff @(posedge CLOCK_I) begin
                if (SRST_I) begin
                    cmp_value[g] <= `TCCU_CMP_RESET;
                end else if (g == 4 && shared_channel_select && cap_event[3]) begin
                    // shared register doubles as the fourth capture's store
                    cmp_value[g] <= cap_value[3];
                end else if (wr_en && hit(word_addr, OFF) && !(g == 4 && shared_channel_select)) begin
                    if (hi_sel) begin
                        cmp_value[g][15:8] <= PWDATA_I[7:0];
                    end else begin
                        cmp_value[g][7:0] <= PWDATA_I[7:0];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // control registers
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            multi_pin_action_mask      <= '0;
            multi_pin_action_data      <= '0;
            compare_pin_action_control <= 8'h00;
            edge_ctl                   <= 8'h00;
            channel_interrupt_enable_register <= 8'h00;
            shared_channel_select      <= 1'b0;
        end else if (wr_en && hi_sel) begin
            if (hit(word_addr, `TCCU_OFF_MASK))   multi_pin_action_mask <= PWDATA_I[7:3];
            if (hit(word_addr, `TCCU_OFF_DATA))   multi_pin_action_data <= PWDATA_I[7:3];
            if (hit(word_addr, `TCCU_OFF_ACTION)) compare_pin_action_control <= PWDATA_I[7:0];
            if (hit(word_addr, `TCCU_OFF_EDGE))   edge_ctl <= PWDATA_I[7:0];
            if (hit(word_addr, `TCCU_OFF_IRQEN))  channel_interrupt_enable_register <= PWDATA_I[7:0];
            if (hit(word_addr, `TCCU_OFF_SELECT)) shared_channel_select <= PWDATA_I[0];
        end
    end

    // force bits wait for the next count transition, one cycle later
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            force_pending <= 5'h00;
        end else if (wr_en && hi_sel && hit(word_addr, `TCCU_OFF_FORCE)) begin
            force_pending <= PWDATA_I[7:3];
        end else begin
            force_pending <= 5'h00;
        end
    end

    // ==========================================================
    // flags: set wins over write-one clear
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            channel_flag_register <= 8'h00;
        end else begin
            channel_flag_register <= (channel_flag_register
                & ~((wr_en && hi_sel && hit(word_addr, `TCCU_OFF_FLAGS)) ? PWDATA_I[7:0] : 8'h00))
                | {cmp_match[0], cmp_match[1], cmp_match[2], cmp_match[3],
                   shared_channel_select ? cap_event[3] : cmp_match[4], cap_event[2:0]};
        end
    end

    // requests follow flag and enable
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            IRQ_O <= 8'h00;
        end else begin
            IRQ_O <= channel_flag_register & channel_interrupt_enable_register;
        end
    end

    // ==========================================================
    // pin actions; match or force, flag state does not matter
    assign act = cmp_match | force_pending;

    always_comb begin
        next_port = PORT_O;
        for (int i = 1; i < 5; i++) begin
            // channel i+1 drives port bit 7-i
            if (act[i] && !(i == 4 && shared_channel_select)) begin
                case (tccu_action_t'(compare_pin_action_control[7-2*(i-1)-:2]))
                    TCCU_ACT_TOGGLE: next_port[7-i] = ~PORT_O[7-i];
                    TCCU_ACT_LOW:    next_port[7-i] = 1'b0;
                    TCCU_ACT_HIGH:   next_port[7-i] = 1'b1;
                    default:         next_port[7-i] = PORT_O[7-i];
                endcase
            end
        end
        // first channel applied last so it takes precedence
        if (act[0]) begin
            next_port = (next_port & ~multi_pin_action_mask)
                      | (multi_pin_action_data & multi_pin_action_mask);
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            PORT_O <= '0;
        end else begin
            PORT_O <= next_port;
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        // the shared offset always reads the one shared store, in either role
        for (int i = 0; i < 3; i++) begin
            if (hit(word_addr, 12'(4*i))) begin
                next_rdata[7:0] = hi_sel ? cap_value[i][15:8] : cap_value[i][7:0];
            end
        end
        for (int i = 0; i < 5; i++) begin
            if ((i < 4 && hit(word_addr, 12'(`TCCU_OFF_CMP1 + 4*i)))
                || (i == 4 && hit(word_addr, `TCCU_OFF_SHARED))) begin
                next_rdata[7:0] = hi_sel ? cmp_value[i][15:8] : cmp_value[i][7:0];
            end
        end
        if (hi_sel) begin
            if (hit(word_addr, `TCCU_OFF_FORCE))  next_rdata[7:0] = 8'h00;
            if (hit(word_addr, `TCCU_OFF_MASK))   next_rdata[7:0] = {multi_pin_action_mask, 3'b000};
            if (hit(word_addr, `TCCU_OFF_DATA))   next_rdata[7:0] = {multi_pin_action_data, 3'b000};
            if (hit(word_addr, `TCCU_OFF_ACTION)) next_rdata[7:0] = compare_pin_action_control;
            if (hit(word_addr, `TCCU_OFF_EDGE))   next_rdata[7:0] = edge_ctl;
            if (hit(word_addr, `TCCU_OFF_FLAGS))  next_rdata[7:0] = channel_flag_register;
            if (hit(word_addr, `TCCU_OFF_IRQEN))  next_rdata[7:0] = channel_interrupt_enable_register;
            if (hit(word_addr, `TCCU_OFF_SELECT)) next_rdata[7:0] = {7'h00, shared_channel_select};
            if (hit(word_addr, `TCCU_OFF_COUNT))  next_rdata[7:0] = free_running_count[15:8];
        end else if (hit(word_addr, `TCCU_OFF_COUNT)) begin
            next_rdata[7:0] = count_low_latch;
        end
    end

    // answer one cycle after setup: pready and data registered
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I && !PENABLE_I;
            PRDATA_O  <= next_rdata;
            PSLVERR_O <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    // flags and requests
    chk_flag_set: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        cmp_match[1] |=> channel_flag_register[6]) else $error("compare flag not set");
    chk_irq_raise: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (channel_flag_register[6] && channel_interrupt_enable_register[6]) |=> IRQ_O[6])
        else $error("request missing");
    chk_irq_drop: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        !channel_flag_register[6] |=> !IRQ_O[6]) else $error("request without flag");
    chk_force_noflag: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (force_pending[0] && !cmp_match[0] && !channel_flag_register[7]
         && !(wr_en && hi_sel && hit(word_addr, `TCCU_OFF_FLAGS))) |=> !channel_flag_register[7])
        else $error("force set a flag");
    chk_flag_clear: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (wr_en && hi_sel && hit(word_addr, `TCCU_OFF_FLAGS) && PWDATA_I[6] && !cmp_match[1])
        |=> !channel_flag_register[6]) else $error("flag not cleared");
    // pin actions, seen one cycle after the action is applied
    chk_mask_drive: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (act[0] && multi_pin_action_mask[7]) |=> PORT_O[7] == $past(multi_pin_action_data[7]))
        else $error("masked bit not driven");
    chk_port_untouched: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (act[0] && !multi_pin_action_mask[5] && !act[2]) |=> PORT_O[5] == $past(PORT_O[5]))
        else $error("unmasked bit moved");
    chk_high_set: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (act[1] && !act[0] && compare_pin_action_control[7:6] == 2'b11) |=> PORT_O[6])
        else $error("set action failed");
    chk_low_clear: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (act[1] && !act[0] && compare_pin_action_control[7:6] == 2'b10) |=> !PORT_O[6])
        else $error("clear action failed");
    chk_toggle_pin: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (act[1] && !act[0] && compare_pin_action_control[7:6] == 2'b01) |=> PORT_O[6] != $past(PORT_O[6]))
        else $error("toggle action failed");
    chk_shared_quiet: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (shared_channel_select && !act[0]) |=> PORT_O[3] == $past(PORT_O[3]))
        else $error("fifth action while capturing");
    // registers, reset and counter
    chk_select_write: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (shared_channel_select && wr_en && hit(word_addr, `TCCU_OFF_SHARED) && !cap_event[3])
        |=> cmp_value[4] == $past(cmp_value[4])) else $error("shared value written while capturing");
    chk_cap_block: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        cap_inhibit[0] |=> !cap_event[0]) else $error("capture during high read");
    chk_unimpl_read: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        (rd_en && hi_sel && hit(word_addr, `TCCU_OFF_MASK)) |-> PRDATA_O[2:0] == 3'b000)
        else $error("unimplemented mask bits not zero");
    chk_reset_ones: assert property (@(posedge CLOCK_I)
        SRST_I |=> cmp_value[0] == `TCCU_CMP_RESET && cmp_value[4] == `TCCU_CMP_RESET)
        else $error("compare reset wrong");
    chk_count_step: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
        1'b1 |=> free_running_count == $past(free_running_count) + WIDTH'(1))
        else $error("counter skipped");
    // covers for the main scenarios
    cov_force: cover property (@(posedge CLOCK_I) force_pending[0]);
    cov_capture: cover property (@(posedge CLOCK_I) cap_event[0]);
    cov_match: cover property (@(posedge CLOCK_I) cmp_match[1] && IRQ_O[6]);
    cov_force_five: cover property (@(posedge CLOCK_I) force_pending[4] && !shared_channel_select);
    cov_toggle: cover property (@(posedge CLOCK_I) act[1] && compare_pin_action_control[7:6] == 2'b01);
endmodule // tccu_top

// ### common/tccu_consts.svh
// register offsets, field positions, reset values and timing counts of the capture/compare unit
`ifndef TCCU_CONSTS_SVH
`define TCCU_CONSTS_SVH

// ==========================================================
// register byte addresses (one aligned word each)
`define TCCU_OFF_CAP1       12'h000
`define TCCU_OFF_CAP2       12'h004
`define TCCU_OFF_CAP3       12'h008
`define TCCU_OFF_SHARED     12'h00C
`define TCCU_OFF_CMP1       12'h010
`define TCCU_OFF_CMP2       12'h014
`define TCCU_OFF_CMP3       12'h018
`define TCCU_OFF_CMP4       12'h01C
`define TCCU_OFF_FORCE      12'h020
`define TCCU_OFF_MASK       12'h024
`define TCCU_OFF_DATA       12'h028
`define TCCU_OFF_COUNT      12'h02C
`define TCCU_OFF_ACTION     12'h030
`define TCCU_OFF_EDGE       12'h034
`define TCCU_OFF_FLAGS      12'h038
`define TCCU_OFF_IRQEN      12'h03C
`define TCCU_OFF_SELECT     12'h040
// byte lanes inside a 16-bit value register: high byte at +0, low byte at +0x80 (word offsets 0x80 apart)
`define TCCU_OFF_LOWBYTE    12'h080

// ==========================================================
// field positions and reset values
`define TCCU_IMPL_MASK      8'hF8
`define TCCU_CMP_RESET      16'hFFFF
`define TCCU_PORT_LO        3
`define TCCU_CH_FLAG_LO     3

// ==========================================================
// timing counts
`define TCCU_INHIBIT_CYCLES 1
`define TCCU_PRESCALE       4'h1

`endif

// ### common/tccu_pkg.sv
// types shared by the capture/compare unit
package tccu_pkg;
    // pin action encodings
    typedef enum logic [1:0] {
        TCCU_ACT_OFF,
        TCCU_ACT_TOGGLE,
        TCCU_ACT_LOW,
        TCCU_ACT_HIGH
    } tccu_action_t;

    // capture edge selections
    typedef enum logic [1:0] {
        TCCU_EDGE_NONE,
        TCCU_EDGE_RISE,
        TCCU_EDGE_FALL,
        TCCU_EDGE_ANY
    } tccu_edge_t;

    // one capture channel's controls
    typedef struct packed {
        logic       enable;
        tccu_edge_t edge_sel;
    } tccu_cap_ctl_t;
endpackage

// ### hw/tccu_capture_chan.sv
// one input capture channel: synchroniser, edge judge and held capture request
`timescale 1ns/1ns
`include "tccu_consts.svh"
module tccu_capture_chan
    import tccu_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // pin and control
    input  wire logic             pin_i,
    input  wire tccu_cap_ctl_t    ctl_i,
    input  wire logic             inhibit_i,
    input  wire logic [WIDTH-1:0] count_i,
    // result
    output logic [WIDTH-1:0]      value_o,
    output logic                  event_o
);
    logic sync_a;
    logic sync_b;
    logic last;
    logic pending;
    logic edge_hit;

    // two-stage synchroniser; first stage only feeds the second
    always_ff @(posedge clk_i) begin
        sync_a <= pin_i;
        sync_b <= sync_a;
        last   <= rst_i ? 1'b0 : sync_b;
    end

    // edge judge on the settled level only
    always_comb begin
        case (ctl_i.edge_sel)
            TCCU_EDGE_RISE: edge_hit = sync_b & ~last;
            TCCU_EDGE_FALL: edge_hit = ~sync_b & last;
            TCCU_EDGE_ANY:  edge_hit = sync_b ^ last;
            default:        edge_hit = 1'b0;
        endcase
    end

    // a blocked capture is held, never dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending <= 1'b0;
            event_o <= 1'b0;
        end else begin
            pending <= ((edge_hit & ctl_i.enable) | pending) & inhibit_i;
            event_o <= ((edge_hit & ctl_i.enable) | pending) & ~inhibit_i;
        end
    end

    // whole-word parallel latch; reset leaves the value alone
    always_ff @(posedge clk_i) begin
        if (((edge_hit & ctl_i.enable) | pending) && !inhibit_i) begin
            value_o <= count_i;
        end
    end

    chk_held_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        (pending && !inhibit_i) |=> event_o) else $error("held capture lost");
endmodule // tccu_capture_chan

// ### hw/tccu_compare_chan.sv
// one output compare channel: comparator with high-byte write inhibit
`timescale 1ns/1ns
`include "tccu_consts.svh"
module tccu_compare_chan #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // compare inputs
    input  wire logic [WIDTH-1:0] value_i,
    input  wire logic [WIDTH-1:0] count_i,
    input  wire logic             inhibit_i,
    // result
    output logic                  match_o
);
    // compare every cycle except the one after a high-byte write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_o <= 1'b0;
        end else begin
            match_o <= (value_i == count_i) && !inhibit_i;
        end
    end

    chk_cmp_inhibit: assert property (@(posedge clk_i) disable iff (rst_i)
        inhibit_i |=> !match_o) else $error("compare not inhibited");
endmodule // tccu_compare_chan

// ### tb/tccu_pin_model.sv
// capture pin driver standing in for the outside world
`timescale 1ns/1ns
module tccu_pin_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // toggle requests from the bench
    input  wire logic [3:0] toggle_i,
    // pin levels seen by the unit
    output logic      [3:0] pin_o
);
    // ==========================================================
    // pins
    // levels change only on a clock edge and are held between edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 4'h0;
        end else begin
            pin_o <= pin_o ^ toggle_i;
        end
    end
endmodule // tccu_pin_model

// ### tb/tccu_top_tb_top.sv
// self-checking bench for the capture/compare unit
`timescale 1ns/1ns
`include "tccu_consts.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin failures++; \
    $display("FAIL %s expected %h seen %h", nm, ex, gt); end end
module tccu_top_tb_top;
    import tccu_pkg::*;
    // ==========================================================
    // signals
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  tog = 4'h0;
    logic [3:0]  pins;
    logic [7:3]  port;
    logic [7:0]  irq;
    int          failures = 0;
    int          n_tests = 0;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [7:0]  q;
    logic [1:0]  modes [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic        lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

    // 100 MHz clock
    always #5 clk = ~clk;

    tccu_top dut (.CLOCK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .CAPTURE_PIN_I(pins), .PORT_O(port), .IRQ_O(irq));
    tccu_pin_model pin_model (.clk_i(clk), .rst_i(srst), .toggle_i(tog), .pin_o(pins));

    // ==========================================================
    // apb master: one idle edge after each transfer so no signal is assigned twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        // only the slave ends the access; the watchdog guards a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata[7:0];
        `CHK("bus upper", 25'h000_0000, {pslverr, prdata[31:8]})
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        apb(1'b1, a, d, r);
    endtask
    // high byte first: a count read latches the low byte
    task automatic rd16(input logic [11:0] a, output logic [15:0] v);
        apb(1'b0, a, 8'h00, v[15:8]);
        apb(1'b0, a + `TCCU_OFF_LOWBYTE, 8'h00, v[7:0]);
    endtask
    task automatic wr16(input logic [11:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + `TCCU_OFF_LOWBYTE, v[7:0]);
    endtask
    task automatic pulse(input logic [3:0] b);
        tog <= b;
        @(posedge clk);
        tog <= 4'h0;
    endtask
    // compare two at count plus 64, then let the match pass
    task automatic match2();
        logic [15:0] c;
        rd16(`TCCU_OFF_COUNT, c);
        wr16(`TCCU_OFF_CMP2, c + 16'h0040);
        repeat (90) @(posedge clk);
    endtask

    // ==========================================================
    // verdict, reached from the sequence or the watchdog
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 700 cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // compare registers come out of reset all ones
        for (int i = 0; i < 5; i++) begin
            rd16(`TCCU_OFF_SHARED + 12'(4 * i), c1);
            `CHK("cmp reset", `TCCU_CMP_RESET, c1)
        end
        // unimplemented low bits read zero
        wr(`TCCU_OFF_MASK, 8'hFF);
        apb(1'b0, `TCCU_OFF_MASK, 8'h00, q);
        `CHK("mask bits", `TCCU_IMPL_MASK, q)
        wr(`TCCU_OFF_DATA, 8'hFF);
        apb(1'b0, `TCCU_OFF_DATA, 8'h00, q);
        `CHK("data bits", `TCCU_IMPL_MASK, q)
        wr(`TCCU_OFF_MASK, 8'h00);
        // capture one on rise, two on fall, edges 100 cycles apart
        wr(`TCCU_OFF_EDGE, 8'h09);
        pulse(4'h2);
        repeat (10) @(posedge clk);
        pulse(4'h1);
        repeat (99) @(posedge clk);
        pulse(4'h2);
        repeat (10) @(posedge clk);
        rd16(`TCCU_OFF_CAP1, c1);
        rd16(`TCCU_OFF_CAP2, c2);
        `CHK("capture span", 16'h0064, c2 - c1)
        wr(`TCCU_OFF_CAP1, ~c1[15:8]);
        rd16(`TCCU_OFF_CAP1, c2);
        `CHK("capture ro", c1, c2)
        // compare two through every mode, with its request enabled
        wr(`TCCU_OFF_IRQEN, 8'h40);
        for (int i = 0; i < 4; i++) begin
            wr(`TCCU_OFF_ACTION, {modes[i], 6'h00});
            match2();
            `CHK("pin two", lvl[i], port[6])
        end
        apb(1'b0, `TCCU_OFF_FLAGS, 8'h00, q);
        `CHK("flags set", 8'h43, q)
        `CHK("request", 8'h40, irq)
        wr(`TCCU_OFF_FLAGS, 8'h40);
        apb(1'b0, `TCCU_OFF_FLAGS, 8'h00, q);
        `CHK("flag clear", 8'h03, q)
        `CHK("request off", 8'h00, irq)
        // shared channel as capture: compare writes ignored, no pin action
        wr(`TCCU_OFF_SELECT, 8'h01);
        wr(`TCCU_OFF_SHARED, 8'h12);
        apb(1'b0, `TCCU_OFF_SHARED, 8'h00, q);
        `CHK("shared ro", 8'hFF, q)
        // forcing channel five: no action while it captures, high once select clears
        wr(`TCCU_OFF_ACTION, 8'h03);
        wr(`TCCU_OFF_FORCE, 8'h80);
        repeat (3) @(posedge clk);
        `CHK("pin five off", 1'b0, port[3])
        wr(`TCCU_OFF_SELECT, 8'h00);
        wr(`TCCU_OFF_FORCE, 8'h80);
        repeat (3) @(posedge clk);
        `CHK("pin five on", 1'b1, port[3])
        // first channel drives masked bits only
        wr(`TCCU_OFF_ACTION, 8'h00);
        wr(`TCCU_OFF_MASK, 8'h88);
        wr(`TCCU_OFF_DATA, 8'h80);
        wr(`TCCU_OFF_FORCE, 8'h08);
        repeat (3) @(posedge clk);
        `CHK("port one", 5'b11000, port)
        apb(1'b0, `TCCU_OFF_FLAGS, 8'h00, q);
        `CHK("force no flag", 8'h03, q)
        // reset again in mid-run: captures survive, compares reload
        srst <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd16(`TCCU_OFF_CAP1, c2);
        `CHK("capture kept", c1, c2)
        rd16(`TCCU_OFF_CMP2, c2);
        `CHK("cmp two reset", `TCCU_CMP_RESET, c2)
        end_of_test();
    end
endmodule // tccu_top_tb_top
